// [instr_source.sv]
// decoder model: presents one instruction in the q4 slot per call
`default_nettype none
module instr_source (
  input  wire logic                 pclk,
  input  wire logic [3:0]           phase,
  output var  logic                 instr_valid,
  output var  pc_stack_pkg::instr_s instr
);
  timeunit 1ns;
  timeprecision 1ps;
  import pc_stack_pkg::*;
  initial begin
    instr_valid = 1'b0;
    instr = '0;
  end
  task automatic issue(op_e o, logic [19:0] t, logic f);
    @(posedge pclk iff phase[2]);
    instr_valid <= 1'b1;
    instr <= '{op: o, fast: f, word_target: t, rel_offset: 11'h000};
    @(posedge pclk);
    instr_valid <= 1'b0;
    // released fields do not keep their last value
    instr <= ~instr;
  endtask
endmodule
`default_nettype wire

// [pc_and_return_stack_unit.sv]
// program counter, return stack and fast shadow stack with apb registers
//
// The register offsets and register access over APB were left to the implementer.
`default_nettype none
module pc_and_return_stack_unit (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  por_n,
  input  wire logic                  dev_reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  instr_valid,
  input  wire pc_stack_pkg::instr_s  instr,
  input  wire pc_stack_pkg::shadow_s regs_in,
  output pc_stack_pkg::shadow_s      regs_out,
  output logic                       regs_restore,
  output logic [20:0]                pc,
  output logic                       flush,
  output logic [3:0]                 phase,
  output logic                       reset_request
);
  import pc_stack_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // phases and apb decode
  logic [3:0] q;
  phase_gen u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (q)
  );
  assign phase = q;

  logic            acc;
  logic            wr;
  logic            rd;
  logic            mapped;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign pready  = 1'b1;
  always_comb begin
    case (paddr)
      A_SP_REG, A_TOPL, A_TOPH, A_TOPU, A_PC_LOW, A_PC_HLAT, A_PC_ULAT,
      A_CFG, A_PC, A_SHADOW: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_nxt;
  logic            full_r;
  logic            unf_r;
  logic            fault_en_r;
  logic [7:0]      lath_r;
  logic [4:0]      latu_r;
  logic [PC_W-1:0] mem_r [1:DEPTH];
  shadow_s         shadow_r;
  logic            flush_r;
  logic            rstreq_r;

  // instructions act in q4 of the execute cycle
  logic exec;
  assign exec = instr_valid && q[3];

  logic is_push;
  logic is_pop;
  always_comb begin
    is_push = 1'b0;
    is_pop  = 1'b0;
    if (exec) begin
      case (instr.op)
        OP_CALL, OP_RELCALL, OP_PUSH, OP_INTR: is_push = 1'b1;
        OP_RETURN, OP_POP: is_pop = 1'b1;
        default: ;
      endcase
    end
  end

  logic push_full;
  logic pop_empty;
  logic fault;
  assign push_full = is_push && (sp_r >= SP_MAX - 5'h1);
  assign pop_empty = is_pop && (sp_r == 5'h00);
  assign fault     = (push_full || pop_empty) && fault_en_r;

  logic [SP_W-1:0] wr_idx;
  assign wr_idx = (sp_r == SP_MAX) ? SP_MAX : sp_r + 5'h1;
  logic [PC_W-1:0] top_val;
  assign top_val = (sp_r == 5'h00) ? PC_RESET : mem_r[sp_r];

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer
  always_comb begin
    sp_nxt = sp_r;
    if (wr && paddr == A_SP_REG) begin
      sp_nxt = pwdata[SP_W-1:0];
    end else if (fault) begin
      sp_nxt = 5'h00;
    end else if (is_push) begin
      sp_nxt = wr_idx;
    end else if (is_pop && sp_r != 5'h00) begin
      sp_nxt = sp_r - 5'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= 5'h00;
    end else if (!dev_reset_n) begin
      sp_r <= 5'h00;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags survive device reset, cleared only by software or por
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      full_r <= 1'b0;
      unf_r  <= 1'b0;
    end else begin
      if (push_full) begin
        full_r <= 1'b1;
      end else if (wr && paddr == A_SP_REG && !pwdata[FULL_BIT]) begin
        full_r <= 1'b0;
      end
      if (pop_empty) begin
        unf_r <= 1'b1;
      end else if (wr && paddr == A_SP_REG && !pwdata[UNF_BIT]) begin
        unf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      fault_en_r <= CFG_RESET;
    end else if (wr && paddr == A_CFG) begin
      fault_en_r <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack memory, level zero has no storage
  genvar gi;
  generate
    for (gi = 1; gi <= DEPTH; gi++) begin : g_lvl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[gi] <= PC_RESET;
        end else if (is_push && wr_idx == gi) begin
          mem_r[gi] <= pc_r + PC_STEP;
        end else if (wr && sp_r == gi && paddr == A_TOPL) begin
          mem_r[gi] <= {mem_r[gi][20:8], pwdata[7:0]};
        end else if (wr && sp_r == gi && paddr == A_TOPH) begin
          mem_r[gi] <= {mem_r[gi][20:16], pwdata[7:0], mem_r[gi][7:0]};
        end else if (wr && sp_r == gi && paddr == A_TOPU) begin
          mem_r[gi] <= {pwdata[4:0], mem_r[gi][15:0]};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // program counter
  logic [PC_W-1:0] rel;
  assign rel = {{9{instr.rel_offset[10]}}, instr.rel_offset, 1'b0};
  always_comb begin
    pc_nxt = pc_r;
    if (wr && paddr == A_PC_LOW) begin
      pc_nxt = {latu_r, lath_r, pwdata[7:1], 1'b0};
    end else if (exec) begin
      case (instr.op)
        OP_CALL, OP_GOTO:
          pc_nxt = {instr.word_target, 1'b0};
        OP_RELCALL, OP_BRA:
          pc_nxt = pc_r + rel;
        OP_RETURN:
          pc_nxt = top_val;
        default: ;
      endcase
    end else if (q[0]) begin
      pc_nxt = pc_r + PC_STEP;
    end
    pc_nxt[0] = 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= PC_RESET;
    end else if (!dev_reset_n || fault) begin
      pc_r <= PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end
  assign pc = pc_r;

  ////////////////////////////////////////////////////////////////////////////
  // latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lath_r <= 8'h00;
      latu_r <= 5'h00;
    end else if (rd && paddr == A_PC_LOW) begin
      lath_r <= pc_r[15:8];
      latu_r <= pc_r[20:16];
    end else begin
      if (wr && paddr == A_PC_HLAT) lath_r <= pwdata[7:0];
      if (wr && paddr == A_PC_ULAT) latu_r <= pwdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow stack and flush
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_r     <= '0;
      regs_restore <= 1'b0;
    end else begin
      regs_restore <= exec && instr.op == OP_RETURN && instr.fast;
      if (exec && (instr.op == OP_INTR ||
                   (instr.op == OP_CALL && instr.fast))) begin
        shadow_r <= regs_in;
      end
    end
  end
  assign regs_out = shadow_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_r <= 1'b0;
    end else if (exec) begin
      case (instr.op)
        OP_CALL, OP_RELCALL, OP_GOTO, OP_BRA, OP_RETURN, OP_INTR:
          flush_r <= 1'b1;
        default: flush_r <= 1'b0;
      endcase
    end else if (q[3]) begin
      flush_r <= 1'b0;
    end
  end
  assign flush = flush_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstreq_r <= 1'b0;
    end else begin
      rstreq_r <= fault;
    end
  end
  assign reset_request = rstreq_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        A_SP_REG: prdata <= {24'h00_0000, full_r, unf_r, 1'b0, sp_r};
        A_TOPL:   prdata <= {24'h00_0000, top_val[7:0]};
        A_TOPH:   prdata <= {24'h00_0000, top_val[15:8]};
        A_TOPU:   prdata <= {27'h000_0000, top_val[20:16]};
        A_PC_LOW:  prdata <= {24'h00_0000, pc_r[7:0]};
        A_PC_HLAT: prdata <= {24'h00_0000, lath_r};
        A_PC_ULAT: prdata <= {27'h000_0000, latu_r};
        A_CFG:    prdata <= {31'h0000_0000, fault_en_r};
        A_PC:     prdata <= {11'h000, pc_r};
        A_SHADOW: prdata <= {8'h00, shadow_r};
        default:  prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// [pc_and_return_stack_unit_bench.sv]
// self-checking bench for the pc and return stack unit
`default_nettype none
module pc_and_return_stack_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pc_stack_pkg::*;
  logic        pclk = 0, presetn = 0, por_n = 0, dev_reset_n = 1;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
  logic        instr_valid, regs_restore, flush, reset_request;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic [20:0] pc;
  logic [3:0]  phase;
  instr_s      instr;
  shadow_s     regs_in = '0, regs_out;
  int          fail_count = 0, checks = 0;
  always #5 pclk = ~pclk;
  pc_and_return_stack_unit DUT (.pclk, .presetn, .por_n, .dev_reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_valid, .instr, .regs_in, .regs_out, .regs_restore, .pc, .flush,
    .phase, .reset_request);
  instr_source SRC (.pclk, .phase, .instr_valid, .instr);
  ////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, {24'h00_0000, e}, rv);
  endtask
  task automatic op(op_e o, logic [19:0] t, logic f);
    SRC.issue(o, t, f);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(A_SP_REG, 8'h00, "pointer at reset");
    rd(A_CFG, 8'h01, "fault enable at reset");
    rd(8'h30, 8'h00, "unmapped read");
    chk("unmapped error", 32'h0000_0001, {31'h0, se});
  endtask
  task automatic t_stack();
    wr(A_CFG, 8'h00);
    op(OP_CALL, 20'h0_0123, 1'b0);
    chk("call pc", 32'h0000_0246, {11'h000, pc});
    chk("call flush", 32'h0000_0001, {31'h0, flush});
    chk("phase after exec", 32'h0000_0001, {28'h000_0000, phase});
    rd(A_SP_REG, 8'h01, "pointer after call");
    op(OP_PUSH, 20'h0_0000, 1'b0);
    rd(A_SP_REG, 8'h02, "pointer after push");
    op(OP_POP, 20'h0_0000, 1'b0);
    rd(A_SP_REG, 8'h01, "pointer after pop");
    op(OP_RETURN, 20'h0_0000, 1'b0);
    op(OP_RETURN, 20'h0_0000, 1'b0);
    chk("underflow pc", 32'h0000_0000, {11'h000, pc});
    rd(A_SP_REG, 8'h40, "underflow flag");
    wr(A_SP_REG, 8'h00);
    rd(A_SP_REG, 8'h00, "flags cleared");
  endtask
  task automatic t_full();
    wr(A_SP_REG, 8'h1e);
    op(OP_PUSH, 20'h0_0000, 1'b0);
    rd(A_SP_REG, 8'h9f, "full at top");
    op(OP_PUSH, 20'h0_0000, 1'b0);
    rd(A_SP_REG, 8'h9f, "overwrite at top");
    wr(A_SP_REG, 8'h1f);
    rd(A_SP_REG, 8'h1f, "full cleared");
    wr(A_CFG, 8'h01);
    wr(A_SP_REG, 8'h1e);
    op(OP_PUSH, 20'h0_0000, 1'b0);
    chk("fault pc", 32'h0000_0000, {11'h000, pc});
    chk("reset request", 32'h0000_0001, {31'h0, reset_request});
    rd(A_SP_REG, 8'h80, "fault reset");
    dev_reset_n <= 1'b0;
    @(posedge pclk);
    dev_reset_n <= 1'b1;
    rd(A_SP_REG, 8'h80, "flag kept");
    presetn <= 1'b0;
    por_n <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rd(A_SP_REG, 8'h00, "power-on clears");
  endtask
  task automatic t_pcl();
    wr(A_PC_HLAT, 8'h12);
    wr(A_PC_ULAT, 8'h03);
    wr(A_PC_LOW, 8'h40);
    apb(1'b0, A_PC, 32'h0000_0000);
    chk("pc upper", 32'h0000_0312, {19'h0_0000, rv[20:8]});
    chk("pc lsb", 32'h0000_0000, {31'h0, rv[0]});
    wr(A_PC_HLAT, 8'h55);
    apb(1'b0, A_PC_LOW, 32'h0000_0000);
    rd(A_PC_HLAT, 8'h12, "latch from low read");
    op(OP_GOTO, 20'h0_0800, 1'b0);
    rd(A_PC_HLAT, 8'h12, "goto keeps latch");
  endtask
  task automatic t_shadow();
    regs_in <= 24'ha1_b2c3;
    op(OP_INTR, 20'h0_0004, 1'b0);
    chk("shadow load", 32'h00a1_b2c3, {8'h00, regs_out});
    @(posedge pclk);
    regs_in <= 24'h5a_6b7c;
    op(OP_INTR, 20'h0_000c, 1'b0);
    chk("shadow overwrite", 32'h005a_6b7c, {8'h00, regs_out});
    op(OP_RETURN, 20'h0_0000, 1'b1);
    se = 1'b0;
    repeat (4) begin
      if (regs_restore === 1'b1) se = 1'b1;
      @(posedge pclk);
    end
    chk("fast restore", 32'h0000_0001, {31'h0, se});
    op(OP_RETURN, 20'h0_0000, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    $display("reset test done");
    t_stack();
    $display("stack test done");
    t_shadow();
    $display("shadow test done");
    t_pcl();
    $display("latch test done");
    t_full();
    $display("full test done");
    tally_and_finish();
  end
  initial begin
    #50_000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [pc_stack_pkg.sv]
// package: register map, fields, reset values and types of the pc/stack unit
// How it works
// - pointer 0..31, zero at reset, push/pop steps
// - software reads and writes pointer anytime
// - full flag after 31 pushes without pop
// - full flag cleared only by software or por
// - fault reset on: push pc+2, flag, reset
// - fault reset off: pointer 31, overwrite top
// - empty pop loads zero, sets underflow flag
// - fault sets flag, resets only when enabled
// - bit7 full, bit6 underflow, bit5 zero, 4:0
// - push instruction stores pc+2, top editable
// - pop instruction discards top by decrement
// - shadow saves status, working, bank registers
// - both interrupt priorities load the shadow
// - 21-bit pc, upper bits via latches
// - pc bit0 zero, advances by two
// - calls and branches bypass the latches
// - low byte write loads latches, read copies
// - clock divided by four phases
// - latch in phase one, read q2, write q4
// - pc change flushes prefetch, two cycles
// - absolute targets are word addresses
// - 31 by 21 storage, level zero empty
`default_nettype none
package pc_stack_pkg;
  localparam int PC_W      = 21;
  localparam int SP_W      = 5;
  localparam int DEPTH     = 31;
  localparam logic [SP_W-1:0] SP_MAX = 5'h1f;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
  localparam int FULL_BIT  = 7;
  localparam int UNF_BIT   = 6;
  // apb byte addresses
  localparam logic [7:0] A_SP_REG = 8'h00;
  localparam logic [7:0] A_TOPL   = 8'h04;
  localparam logic [7:0] A_TOPH   = 8'h08;
  localparam logic [7:0] A_TOPU   = 8'h0c;
  localparam logic [7:0] A_PC_LOW  = 8'h10;
  localparam logic [7:0] A_PC_HLAT = 8'h14;
  localparam logic [7:0] A_PC_ULAT = 8'h18;
  localparam logic [7:0] A_CFG    = 8'h1c;
  localparam logic [7:0] A_PC     = 8'h20;
  localparam logic [7:0] A_SHADOW = 8'h24;
  localparam logic       CFG_RESET = 1'b1;
  typedef enum logic [3:0] {
    OP_NONE, OP_CALL, OP_RELCALL, OP_GOTO, OP_BRA, OP_RETURN,
    OP_PUSH, OP_POP, OP_INTR
  } op_e;
  typedef struct packed {
    op_e              op;
    logic             fast;
    logic [19:0]      word_target;
    logic [10:0]      rel_offset;
  } instr_s;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_reg;
    logic [7:0] bank_select_reg;
  } shadow_s;
endpackage
`default_nettype wire

// [pc_stack_props.sv]
// assertions on the ports of the pc and return stack unit
`default_nettype none
module pc_stack_props (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  dev_reset_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic                  instr_valid,
  input wire pc_stack_pkg::instr_s  instr,
  input wire pc_stack_pkg::shadow_s regs_in,
  input wire pc_stack_pkg::shadow_s regs_out,
  input wire logic                  regs_restore,
  input wire logic [20:0]           pc,
  input wire logic                  flush,
  input wire logic [3:0]            phase,
  input wire logic                  reset_request
);
  import pc_stack_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take;
  assign take = instr_valid && phase[3] && dev_reset_n;
  ////////////////////////////////////////////////////////////////
  chk_pc_even: assert property (pc[0] == 1'b0)
    else $error("pc lsb set");
  chk_phase_turn: assert property ($past(presetn) &&
    $onehot($past(phase)) |-> phase == {$past(phase[2:0]), $past(phase[3])})
    else $error("phase did not rotate");
  chk_pc_hold: assert property (phase[1] && !psel && dev_reset_n
    |=> $stable(pc)) else $error("pc moved in q2");
  chk_call_target: assert property (take && instr.op == OP_CALL
    |=> reset_request || pc == {$past(instr.word_target), 1'b0})
    else $error("call target wrong");
  chk_branch_flush: assert property (take &&
    instr.op inside {OP_CALL, OP_GOTO} |=> flush)
    else $error("no flush after branch");
  chk_reset_pulse: assert property (reset_request |=> !reset_request)
    else $error("reset request too long");
  chk_restore_pulse: assert property (regs_restore |=> !regs_restore)
    else $error("restore too long");
  chk_shadow_load: assert property (take && instr.op == OP_INTR
    |=> regs_out == $past(regs_in)) else $error("shadow not loaded");
  chk_sp_read_zero: assert property (psel && !penable && !pwrite &&
    paddr == A_SP_REG |=> prdata[31:8] == 24'h00_0000 && !prdata[5])
    else $error("pointer reserved bits set");
  chk_err_unmapped: assert property (psel && penable &&
    paddr > A_SHADOW |-> pslverr) else $error("no error on unmapped");
endmodule
bind pc_and_return_stack_unit pc_stack_props PROPS (.pclk, .presetn,
  .dev_reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
  .instr_valid, .instr, .regs_in, .regs_out, .regs_restore, .pc, .flush,
  .phase, .reset_request);
`default_nettype wire

// [phase_gen.sv]
// four-phase generator from the core clock
`default_nettype none
module phase_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic [3:0]      q
);
  logic [1:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  assign q = 4'h1 << cnt_r;
endmodule
`default_nettype wire
